// ===== src/oem_pkg.sv
// Shared constants and types of the output override and enable monitor
// Contract
// - Override drives selected outputs to pattern
// - Selection bits choose outputs; five picks one, three
// - Pattern bits give forced states; two clears both
// - Up key function two issues override
// - Freeze holds all outputs while commanded
// - Selection eight turns command into freeze
// - First input function two issues relay action
// - Polarity one makes command active high
// - Release resumes comparison states at once
// - Alarm when disabled yet still rotating
// - Alarm when enabled but not reaching speed
// - Alarm when no standstill after disable
// - Function twelve on an input starts monitoring
// - Polarity sets which level means disabled
// - Start-up delay suppresses underspeed output evaluation
// - Alarm appears on the underspeed output
// - Status asserted while command is disabled
package oem_pkg;
  localparam int          NUM_OUT           = 3;
  localparam int          FUNC_W            = 4;
  localparam int          SEL_W             = 4;
  localparam int          PAT_W             = 3;
  localparam int          IDX_W             = 2;
  localparam int          TMR_W             = 24;
  localparam int          SYNC_W            = 3;
  localparam logic [FUNC_W-1:0] FUNC_RELAY_ACTION = 4'h2;
  localparam logic [FUNC_W-1:0] FUNC_CMD_MON      = 4'hc;
  localparam logic [FUNC_W-1:0] KEY_OVERRIDE      = 4'h2;
  localparam logic [SEL_W-1:0]  SEL_FREEZE        = 4'h8;
  localparam logic        POL_ACTIVE_HIGH   = 1'b1;
  localparam logic        POL_DIS_LOW       = 1'b0;
  localparam logic [NUM_OUT-1:0] OUT_RESET  = 3'h0;
  localparam logic [IDX_W-1:0]   IDX_ONE    = 2'h0;
  localparam int          SYN_KEY           = 0;
  localparam int          SYN_IN1           = 1;
  localparam int          SYN_IN2           = 2;

  typedef enum logic [1:0] {
    MON_OFF = 2'b00,
    MON_EN  = 2'b01,
    MON_DIS = 2'b10
  } oem_mon_e;
endpackage

// ===== src/oem_sync.sv
// Two-stage synchroniser for key and control inputs
`timescale 1ns/1ps
`default_nettype none
module oem_sync #(
  parameter int W = 3
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } oem_sync_s;

  oem_sync_s st_ff;
  oem_sync_s nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d_in;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_out = st_ff.s2;
endmodule
`default_nettype wire

// ===== src/oem_timer.sv
// Retriggerable down counter for start-up and standstill windows
`timescale 1ns/1ps
`default_nettype none
module oem_timer #(
  parameter int W = 24
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic         start,
  input  wire logic [W-1:0] len,
  output logic              busy
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
  } oem_tmr_s;

  oem_tmr_s st_ff;
  oem_tmr_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (start) begin
      nxt_st.cnt  = len;
      nxt_st.busy = (len != '0);
    end else if (st_ff.busy) begin
      nxt_st.cnt = W'(st_ff.cnt - 1'b1);
      if (st_ff.cnt == W'(1)) begin
        nxt_st.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.busy;
endmodule
`default_nettype wire

// ===== src/oem_monitor.sv
// Output override, freeze and remote enable monitor top
`timescale 1ns/1ps
`default_nettype none
module oem_monitor #(
  parameter int TW = oem_pkg::TMR_W
) (
  input  wire logic                          mclk,
  input  wire logic                          arst_n,
  input  wire logic [oem_pkg::NUM_OUT-1:0]   cmp_in,
  input  wire logic                          zero_freq,
  input  wire logic                          below_under,
  input  wire logic                          standstill,
  input  wire logic                          key_up,
  input  wire logic                          ctrl1_in,
  input  wire logic                          ctrl2_in,
  input  wire logic [oem_pkg::FUNC_W-1:0]    key_up_func,
  input  wire logic [oem_pkg::FUNC_W-1:0]    ctrl1_func,
  input  wire logic                          ctrl1_pol,
  input  wire logic [oem_pkg::FUNC_W-1:0]    ctrl2_func,
  input  wire logic                          ctrl2_pol,
  input  wire logic [oem_pkg::SEL_W-1:0]     relay_action_sel,
  input  wire logic [oem_pkg::PAT_W-1:0]     action_pattern,
  input  wire logic [oem_pkg::IDX_W-1:0]     under_idx,
  input  wire logic [TW-1:0]                 startup_len,
  input  wire logic [TW-1:0]                 standstill_len,
  output logic      [oem_pkg::NUM_OUT-1:0]   sw_out,
  output logic                               cmd_disabled,
  output logic                               monitor_active,
  output logic                               monitor_alarm
);
  typedef struct packed {
    logic [oem_pkg::NUM_OUT-1:0] outs;
    oem_pkg::oem_mon_e           mon;
    logic                        en_prev;
    logic                        stop_prev;
    logic                        stop_alarm;
    logic                        alarm;
    logic                        alarm_out;
    logic                        disabled;
    logic                        active;
  } oem_st_s;

  oem_st_s st_ff;
  oem_st_s nxt_st;

  logic [oem_pkg::SYNC_W-1:0]  raw_in;
  logic [oem_pkg::SYNC_W-1:0]  syn_in;
  logic                        key_s;
  logic                        in1_s;
  logic                        in2_s;
  logic                        in1_act;
  logic                        in2_act;
  logic                        act_cmd;
  logic                        freeze_sel;
  logic [oem_pkg::NUM_OUT-1:0] sel_mask;
  logic                        mon_on;
  logic                        en_lvl;
  logic                        dly_start;
  logic                        stop_start;
  logic                        dly_busy;
  logic                        stop_busy;
  logic                        in_delay;
  logic                        stop_expire;
  logic                        run_fault;
  logic                        dis_fault;

  assign raw_in[oem_pkg::SYN_KEY] = key_up;
  assign raw_in[oem_pkg::SYN_IN1] = ctrl1_in;
  assign raw_in[oem_pkg::SYN_IN2] = ctrl2_in;

  oem_sync #(
    .W (oem_pkg::SYNC_W)
  ) u_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d_in   (raw_in),
    .q_out  (syn_in)
  );

  assign key_s = syn_in[oem_pkg::SYN_KEY];
  assign in1_s = syn_in[oem_pkg::SYN_IN1];
  assign in2_s = syn_in[oem_pkg::SYN_IN2];

  // Command decode
  always_comb begin
    in1_act = (ctrl1_pol == oem_pkg::POL_ACTIVE_HIGH) ? in1_s : ~in1_s;
    in2_act = (ctrl2_pol == oem_pkg::POL_ACTIVE_HIGH) ? in2_s : ~in2_s;
    act_cmd = ((key_up_func == oem_pkg::KEY_OVERRIDE) && key_s)
            | ((ctrl1_func == oem_pkg::FUNC_RELAY_ACTION) && in1_act)
            | ((ctrl2_func == oem_pkg::FUNC_RELAY_ACTION) && in2_act);
    freeze_sel = (relay_action_sel == oem_pkg::SEL_FREEZE);
    sel_mask   = relay_action_sel[oem_pkg::NUM_OUT-1:0];
  end

  // Enable input selection and level meaning
  always_comb begin
    mon_on = 1'b0;
    en_lvl = 1'b0;
    if (ctrl1_func == oem_pkg::FUNC_CMD_MON) begin
      mon_on = 1'b1;
      en_lvl = (ctrl1_pol == oem_pkg::POL_DIS_LOW) ? in1_s : ~in1_s;
    end else if (ctrl2_func == oem_pkg::FUNC_CMD_MON) begin
      mon_on = 1'b1;
      en_lvl = (ctrl2_pol == oem_pkg::POL_DIS_LOW) ? in2_s : ~in2_s;
    end
  end

  assign dly_start  = mon_on && st_ff.active && (en_lvl != st_ff.en_prev);
  assign stop_start = mon_on && st_ff.active && st_ff.en_prev && !en_lvl;

  oem_timer #(
    .W (TW)
  ) u_dly (
    .mclk   (mclk),
    .arst_n (arst_n),
    .start  (dly_start),
    .len    (startup_len),
    .busy   (dly_busy)
  );

  oem_timer #(
    .W (TW)
  ) u_stop (
    .mclk   (mclk),
    .arst_n (arst_n),
    .start  (stop_start),
    .len    (standstill_len),
    .busy   (stop_busy)
  );

  assign in_delay    = dly_busy || dly_start;
  assign stop_expire = st_ff.stop_prev && !stop_busy && !stop_start;
  assign run_fault   = en_lvl && !in_delay && (zero_freq || below_under);
  assign dis_fault   = !en_lvl && !in_delay && !stop_busy
                    && !stop_start && !zero_freq;

  // State update
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.active    = mon_on;
    nxt_st.en_prev   = en_lvl;
    nxt_st.stop_prev = stop_busy;
    nxt_st.disabled  = mon_on && !en_lvl;
    if (!mon_on) begin
      nxt_st.mon = oem_pkg::MON_OFF;
    end else if (en_lvl) begin
      nxt_st.mon = oem_pkg::MON_EN;
    end else begin
      nxt_st.mon = oem_pkg::MON_DIS;
    end
    // Set wins over the clear by re-enable
    if (mon_on && stop_expire && !standstill) begin
      nxt_st.stop_alarm = 1'b1;
    end else if (!mon_on || (en_lvl && !st_ff.en_prev)) begin
      nxt_st.stop_alarm = 1'b0;
    end
    unique case (st_ff.mon)
      oem_pkg::MON_EN:  nxt_st.alarm = mon_on && run_fault;
      oem_pkg::MON_DIS: nxt_st.alarm = mon_on && dis_fault;
      oem_pkg::MON_OFF: nxt_st.alarm = 1'b0;
      default:          nxt_st.alarm = 1'b0;
    endcase
    // Registered alarm pin, run or disable alarm or sticky stop alarm
    nxt_st.alarm_out = nxt_st.alarm | nxt_st.stop_alarm;
    // Output resolution, one pass per output
    for (int i = 0; i < oem_pkg::NUM_OUT; i++) begin
      if (act_cmd && freeze_sel) begin
        nxt_st.outs[i] = st_ff.outs[i];
      end else if (act_cmd && sel_mask[i]) begin
        nxt_st.outs[i] = action_pattern[i];
      end else if (mon_on && (under_idx == oem_pkg::IDX_W'(i))) begin
        nxt_st.outs[i] = in_delay ? 1'b0
                       : (cmp_in[i] | st_ff.alarm | st_ff.stop_alarm);
      end else begin
        nxt_st.outs[i] = cmp_in[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff      <= '0;
      st_ff.outs <= oem_pkg::OUT_RESET;
      st_ff.mon  <= oem_pkg::MON_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sw_out         = st_ff.outs;
  assign cmd_disabled   = st_ff.disabled;
  assign monitor_active = st_ff.active;
  assign monitor_alarm  = st_ff.alarm_out;

  // Checks
  override_force_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (act_cmd && !freeze_sel && !mon_on) |=>
      ((sw_out & $past(sel_mask)) == ($past(action_pattern) & $past(sel_mask))))
    else $error("selected output not forced to pattern");
  unselected_run_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (act_cmd && !freeze_sel && !mon_on) |=>
      ((sw_out & ~$past(sel_mask)) == ($past(cmp_in) & ~$past(sel_mask))))
    else $error("unselected output not following comparison");
  pattern_two_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (act_cmd && relay_action_sel == 4'h5 && action_pattern == 3'h2 && !mon_on)
      |=> (sw_out[0] == 1'b0 && sw_out[2] == 1'b0))
    else $error("pattern two did not clear outputs one and three");
  freeze_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (act_cmd && freeze_sel) |=> $stable(sw_out))
    else $error("outputs moved during freeze");
  resume_cmp_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (!act_cmd && !mon_on) |=> (sw_out == $past(cmp_in)))
    else $error("outputs did not resume comparison state");
  disabled_status_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (mon_on && !en_lvl) |=> cmd_disabled)
    else $error("disabled status missing");
  delay_suppress_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (dly_start && !act_cmd) |=> !sw_out[$past(under_idx)])
    else $error("underspeed output active during start-up delay");
  run_alarm_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_ff.mon == oem_pkg::MON_EN && mon_on && run_fault) |=> monitor_alarm)
    else $error("no alarm when enabled without motion");
  stop_alarm_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (mon_on && stop_expire && !standstill) |=> monitor_alarm [*2])
    else $error("no alarm when standstill not reached");
  sync_delay_a: assert property (@(posedge mclk) disable iff (!arst_n)
    ##3 (key_s == $past(key_up, 2)))
    else $error("key not passed through two stages");

  override_c: cover property (@(posedge mclk) disable iff (!arst_n)
    act_cmd && !freeze_sel ##1 !act_cmd);
  freeze_c: cover property (@(posedge mclk) disable iff (!arst_n)
    (act_cmd && freeze_sel) [*3]);
  stop_fault_c: cover property (@(posedge mclk) disable iff (!arst_n)
    mon_on && stop_expire && !standstill);
  run_fault_c: cover property (@(posedge mclk) disable iff (!arst_n)
    mon_on && en_lvl && !in_delay && below_under);
endmodule
`default_nettype wire

// ===== tb/oem_remote_model.sv
// Remote controller model driving the first control input
`timescale 1ns/1ps
`default_nettype none
module oem_remote_model (
  input  wire logic mclk,
  input  wire logic mon_mode,
  input  wire logic en_req,
  input  wire logic act_req,
  input  wire logic pol,
  input  wire logic slow,
  output var  logic ctrl1_in
);
  logic       level;
  logic [1:0] hist;
  // Enable level per polarity, or relay action level per polarity
  assign level = mon_mode ? (en_req ^ pol) : (act_req ~^ pol);
  initial begin
    hist     = 2'h0;
    ctrl1_in = 1'b0;
  end
  // Static levels only, optionally lagging two cycles
  always @(posedge mclk) begin
    hist     <= {hist[0], level};
    ctrl1_in <= slow ? hist[1] : level;
  end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the override, freeze and enable monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
  end
module testbench;
  logic                          mclk = 1'b0;
  logic                          arst_n = 1'b0;
  logic [oem_pkg::NUM_OUT-1:0]   cmp_in = 3'h0;
  logic                          zero_freq = 1'b1;
  logic                          below_under = 1'b0;
  logic                          standstill = 1'b1;
  logic                          key_up = 1'b0;
  logic                          ctrl1_in;
  logic                          ctrl2_in = 1'b0;
  logic [oem_pkg::FUNC_W-1:0]    key_up_func = 4'h0;
  logic [oem_pkg::FUNC_W-1:0]    ctrl1_func = 4'h0;
  logic [oem_pkg::FUNC_W-1:0]    ctrl2_func = 4'h0;
  logic                          ctrl2_pol = 1'b0;
  logic [oem_pkg::SEL_W-1:0]     relay_action_sel = 4'h0;
  logic [oem_pkg::PAT_W-1:0]     action_pattern = 3'h0;
  logic [oem_pkg::IDX_W-1:0]     under_idx = 2'h0;
  logic [oem_pkg::NUM_OUT-1:0]   sw_out;
  logic                          cmd_disabled;
  logic                          monitor_active;
  logic                          monitor_alarm;
  logic                          m_mode = 1'b0;
  logic                          m_en = 1'b0;
  logic                          m_act = 1'b0;
  logic                          m_pol = 1'b1;
  logic                          m_slow = 1'b0;
  logic [31:0]                   seed = 32'h00010132;
  int                            bad_count = 0;
  int                            check_count = 0;

  oem_monitor dut (
    .mclk(mclk), .arst_n(arst_n), .cmp_in(cmp_in), .zero_freq(zero_freq),
    .below_under(below_under), .standstill(standstill), .key_up(key_up),
    .ctrl1_in(ctrl1_in), .ctrl2_in(ctrl2_in), .key_up_func(key_up_func),
    .ctrl1_func(ctrl1_func), .ctrl1_pol(m_pol), .ctrl2_func(ctrl2_func),
    .ctrl2_pol(ctrl2_pol), .relay_action_sel(relay_action_sel),
    .action_pattern(action_pattern), .under_idx(under_idx),
    .startup_len(24'h000006), .standstill_len(24'h00000c),
    .sw_out(sw_out), .cmd_disabled(cmd_disabled),
    .monitor_active(monitor_active), .monitor_alarm(monitor_alarm)
  );
  oem_remote_model remote (
    .mclk(mclk), .mon_mode(m_mode), .en_req(m_en), .act_req(m_act),
    .pol(m_pol), .slow(m_slow), .ctrl1_in(ctrl1_in)
  );

  initial begin
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [2:0] exp_force(input logic [2:0] c, s, p);
    return (c & ~s) | (p & s);
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic test_key;
    key_up_func = oem_pkg::KEY_OVERRIDE;
    relay_action_sel = 4'h5;
    action_pattern = 3'h2;
    cmp_in = 3'h7;
    wait_n(4);
    `CHK("idle out", 3'h7, sw_out)
    key_up = 1'b1;
    wait_n(1);
    `CHK("sync lag", 3'h7, sw_out)
    wait_n(3);
    `CHK("key force", 3'h2, sw_out)
    cmp_in = 3'h5;
    wait_n(4);
    `CHK("key free bit", 3'h0, sw_out)
    key_up = 1'b0;
    wait_n(4);
    `CHK("key release", 3'h5, sw_out)
    $display("test key override done");
  endtask

  task automatic test_rand;
    logic [2:0] sel;
    logic [2:0] pat;
    logic [2:0] cmp;
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      {sel, pat, cmp} = seed[8:0];
      relay_action_sel = {1'b0, sel};
      action_pattern = pat;
      cmp_in = cmp;
      m_pol = seed[10];
      m_slow = seed[11];
      ctrl2_pol = seed[13];
      ctrl2_in = ~seed[13];
      ctrl1_func = seed[9] ? oem_pkg::FUNC_RELAY_ACTION : 4'h0;
      ctrl2_func = (!seed[9] && seed[14]) ? oem_pkg::FUNC_RELAY_ACTION : 4'h0;
      key_up_func = (seed[9] || seed[14]) ? 4'h0 : oem_pkg::KEY_OVERRIDE;
      wait_n(8);
      if (seed[9]) begin
        m_act = 1'b1;
      end else if (seed[14]) begin
        ctrl2_in = seed[13];
      end else begin
        key_up = 1'b1;
      end
      wait_n(8);
      `CHK("rand force", exp_force(cmp, sel, pat), sw_out)
      m_act = 1'b0;
      ctrl2_in = ~seed[13];
      key_up = 1'b0;
      wait_n(8);
      `CHK("rand release", cmp, sw_out)
    end
    $display("test random override done");
  endtask

  task automatic test_freeze;
    key_up_func = 4'h0;
    ctrl2_func = 4'h0;
    ctrl1_func = oem_pkg::FUNC_RELAY_ACTION;
    m_pol = 1'b1;
    m_slow = 1'b0;
    relay_action_sel = oem_pkg::SEL_FREEZE;
    cmp_in = 3'h3;
    wait_n(8);
    m_act = 1'b1;
    wait_n(6);
    cmp_in = 3'h4;
    wait_n(6);
    `CHK("freeze hold", 3'h3, sw_out)
    m_act = 1'b0;
    wait_n(6);
    `CHK("freeze release", 3'h4, sw_out)
    $display("test freeze done");
  endtask

  task automatic set_en(input logic e);
    m_en     = e;
    ctrl2_in = e ^ ctrl2_pol;
  endtask

  task automatic test_mon(input logic p, input logic use2);
    logic [1:0] u;
    seed = lfsr(seed);
    u = (seed[1:0] == 2'h3) ? 2'h1 : seed[1:0];
    under_idx = u;
    relay_action_sel = 4'h0;
    ctrl1_func = use2 ? 4'h0 : oem_pkg::FUNC_CMD_MON;
    ctrl2_func = use2 ? oem_pkg::FUNC_CMD_MON : 4'h0;
    ctrl2_pol = p;
    m_pol = p;
    m_mode = 1'b1;
    m_slow = 1'b0;
    set_en(1'b0);
    cmp_in = 3'h0;
    {zero_freq, standstill, below_under} = 3'h7;
    wait_n(30);
    `CHK("mon active", 1'b1, monitor_active)
    `CHK("cmd disabled", 1'b1, cmd_disabled)
    `CHK("quiet", 1'b0, monitor_alarm)
    cmp_in = 3'h7;
    set_en(1'b1);
    wait_n(5);
    `CHK("start delay", 1'b0, sw_out[u])
    cmp_in = 3'h0;
    wait_n(20);
    `CHK("run alarm", 1'b1, monitor_alarm)
    `CHK("alarm out", 1'b1, sw_out[u])
    `CHK("cmd enabled", 1'b0, cmd_disabled)
    {zero_freq, below_under} = 2'h0;
    wait_n(5);
    `CHK("run ok", 1'b0, monitor_alarm)
    below_under = 1'b1;
    wait_n(5);
    `CHK("slow alarm", 1'b1, monitor_alarm)
    below_under = 1'b0;
    wait_n(5);
    `CHK("slow clear", 1'b0, monitor_alarm)
    standstill = 1'b0;
    set_en(1'b0);
    wait_n(30);
    `CHK("moving alarm", 1'b1, monitor_alarm)
    {zero_freq, standstill} = 2'h3;
    wait_n(5);
    `CHK("stop sticky", 1'b1, monitor_alarm)
    zero_freq = 1'b0;
    set_en(1'b1);
    wait_n(30);
    `CHK("rearm", 1'b0, monitor_alarm)
    m_mode = 1'b0;
    ctrl1_func = 4'h0;
    ctrl2_func = 4'h0;
    wait_n(6);
    $display("test command monitor done");
  endtask

  initial begin
    #50us;
    bad_count++;
    report_and_stop();
  end

  initial begin
    wait_n(6);
    arst_n = 1'b1;
    wait_n(2);
    test_key();
    test_rand();
    test_freeze();
    test_mon(1'b0, 1'b0);
    test_mon(1'b1, 1'b0);
    test_mon(1'b1, 1'b1);
    test_mon(1'b0, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
